// ===== design/hols_pkg.sv
package hols_pkg;

    // Axis position and method code widths
    localparam int unsigned POS_W    = 32;
    localparam int unsigned METHOD_W = 8;
    localparam int unsigned CW_W     = 16;

    // Control word values around the homing start transition
    localparam logic [15:0] CW_OP_ENABLED  = 16'h000F;
    localparam logic [15:0] CW_HOMING_GO   = 16'h001F;
    localparam int unsigned CW_HOMING_BIT  = 4;

    // Supported homing methods
    localparam logic [7:0] METHOD_ORG_ONLY = 8'h16;  // method 22
    localparam logic [7:0] METHOD_PL_A     = 8'h17;  // method 23
    localparam logic [7:0] METHOD_PL_B     = 8'h18;  // method 24
    localparam logic [7:0] METHOD_PL_C     = 8'h19;  // method 25
    localparam logic [7:0] METHOD_PL_D     = 8'h1A;  // method 26

    // Situation: origin level at start, or limit seen during first run
    localparam logic [1:0] SIT_CLEAR  = 2'h0;  // origin inactive at start
    localparam logic [1:0] SIT_ACTIVE = 2'h1;  // origin active at start
    localparam logic [1:0] SIT_LIMIT  = 2'h2;  // positive limit hit first

    // Step index width and reset values
    localparam logic [1:0] STEP_FIRST = 2'h0;
    localparam logic [POS_W-1:0] HOME_POS_RST = 32'h0000_0000;

    // Input bit positions in the synchroniser vector
    localparam int unsigned IN_ORG = 0;
    localparam int unsigned IN_LIM = 1;
    localparam int unsigned IN_NUM = 2;

    // One motion segment of a homing sequence
    typedef struct packed {
        logic last;     // ending edge latches home
        logic on_fall;  // ends on origin falling edge, else rising
        logic fast;     // high speed, else low speed
        logic neg;      // negative direction, else positive
    } hols_seg_t;

    // Sequencer states, Gray along idle, run, done
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_RUN   = 2'b01,
        ST_DONE  = 2'b11,
        ST_FAULT = 2'b10
    } hols_state_t;

endpackage : hols_pkg

// ===== design/hols_sync_edge.sv
`timescale 1ns/100ps
`default_nettype none

module hols_sync_edge #(
    parameter int unsigned WIDTH = 2
) (
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             reset,
    // Raw switch levels from pins
    input  wire logic [WIDTH-1:0] async_in,
    // Synchronised level and edge pulses
    output logic      [WIDTH-1:0] level,
    output logic      [WIDTH-1:0] rise,
    output logic      [WIDTH-1:0] fall
);

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1)
        begin : g_bit
            logic meta_reg;  // First stage, read only by second
            logic sync_reg;  // Second stage, safe to use
            logic prev_reg;  // Delayed copy for edge detection

            // Two-flop synchroniser plus one history stage
            always_ff @(posedge ref_clk)
            begin
                if (reset)
                begin
                    meta_reg <= 1'b0;
                    sync_reg <= 1'b0;
                    prev_reg <= 1'b0;
                end
                else
                begin
                    meta_reg <= async_in[i];
                    sync_reg <= meta_reg;
                    prev_reg <= sync_reg;
                end
            end

            // Edges only from settled stages
            assign level[i] = sync_reg;
            assign rise[i]  = sync_reg & ~prev_reg;
            assign fall[i]  = ~sync_reg & prev_reg;
        end
    endgenerate

endmodule : hols_sync_edge

`default_nettype wire

// ===== design/hols_start_det.sv
`timescale 1ns/100ps
`default_nettype none

module hols_start_det (
    // Clock and reset
    input  wire logic                       ref_clk,
    input  wire logic                       reset,
    // Control word from the motion master
    input  wire logic [hols_pkg::CW_W-1:0]  ctrl_word,
    // Start pulse and homing-enable level
    output logic                            start_pulse,
    output logic                            homing_on
);

    logic [hols_pkg::CW_W-1:0] prev_reg;  // Last cycle's control word

    // Hold previous word to see the transition
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            prev_reg <= 16'h0000;
        else
            prev_reg <= ctrl_word;
    end

    // Only the exact ready-to-go change starts homing
    assign start_pulse = (prev_reg == hols_pkg::CW_OP_ENABLED) &&
                         (ctrl_word == hols_pkg::CW_HOMING_GO);
    assign homing_on   = ctrl_word[hols_pkg::CW_HOMING_BIT];

endmodule : hols_start_det

`default_nettype wire

// ===== design/hols_seq.sv
// Function
// R1: M22 origin off: negative slow, home rising
// R2: M22 origin on: positive, fall reverses, home rising
// R3: M23 off: positive fast, rise negative slow, home fall
// R4: M23 on: negative slow, home at falling edge
// R5: M23 limit: negative fast, rise slow, home fall
// R6: M24 off: fast, rise neg slow, fall pos, rise
// R7: M24 on: negative slow, fall positive, home rising
// R8: M24 limit: neg fast, rise slow, fall pos, rise
// R9: M25 off: fast, rise slow, fall neg, home rise
// R10: M25 on: positive slow, fall negative, home rise
// R11: M25 limit: neg fast, rise pos, fall neg, rise
// R12: M26 off: positive fast, rise slow, home fall
// R13: M26 on: positive slow, home at falling edge
// R14: M26 limit: neg fast, rise pos slow, home fall
// R15: Master starts homing with control word change
// R16: Synchronised edges; latch home, stop, signal done
// R17: Limit during first fast run selects limit path
`timescale 1ns/100ps
`default_nettype none

module hols_seq (
    // Clock and reset
    input  wire logic                          ref_clk,
    input  wire logic                          reset,
    // Switch pins, asynchronous
    input  wire logic                          origin_in,
    input  wire logic                          pos_limit_in,
    // Motion master command
    input  wire logic [hols_pkg::CW_W-1:0]     ctrl_word,
    input  wire logic [hols_pkg::METHOD_W-1:0] homing_method,
    // Axis feedback
    input  wire logic [hols_pkg::POS_W-1:0]    axis_pos,
    // Motion command outputs
    output logic                               move_en,
    output logic                               speed_fast,
    output logic                               dir_neg,
    // Homing result
    output logic [hols_pkg::POS_W-1:0]         home_pos,
    output logic                               home_latch,
    output logic                               homing_busy,
    output logic                               homing_done,
    output logic                               homing_fault
);

    // Build one segment descriptor
    function automatic hols_pkg::hols_seg_t mk(
        input logic last,
        input logic on_fall,
        input logic fast,
        input logic neg
    );
        hols_pkg::hols_seg_t s;
        s.last    = last;
        s.on_fall = on_fall;
        s.fast    = fast;
        s.neg     = neg;
        return s;
    endfunction : mk

    // Segment table: method, situation and step to motion and end edge
    function automatic hols_pkg::hols_seg_t seg_of(
        input logic [hols_pkg::METHOD_W-1:0] method,
        input logic [1:0]                    sit,
        input logic [1:0]                    step
    );
        hols_pkg::hols_seg_t s;
        s = mk(1'b1, 1'b0, 1'b0, 1'b0);
        unique case (method)
            hols_pkg::METHOD_ORG_ONLY:
            begin
                if (sit == hols_pkg::SIT_CLEAR)
                    s = mk(1'b1, 1'b0, 1'b0, 1'b1);         // R1
                else if (step == 2'h0)
                    s = mk(1'b0, 1'b1, 1'b0, 1'b0);         // R2
                else
                    s = mk(1'b1, 1'b0, 1'b0, 1'b1);         // R2
            end
            hols_pkg::METHOD_PL_A:
            begin
                if (sit == hols_pkg::SIT_ACTIVE)
                    s = mk(1'b1, 1'b1, 1'b0, 1'b1);         // R4
                else if (step == 2'h0)
                    s = mk(1'b0, 1'b0, 1'b1,
                           sit == hols_pkg::SIT_LIMIT);     // R3 R5
                else
                    s = mk(1'b1, 1'b1, 1'b0, 1'b1);         // R3 R5
            end
            hols_pkg::METHOD_PL_B:
            begin
                if (sit == hols_pkg::SIT_ACTIVE)
                begin
                    if (step == 2'h0)
                        s = mk(1'b0, 1'b1, 1'b0, 1'b1);     // R7
                    else
                        s = mk(1'b1, 1'b0, 1'b0, 1'b0);     // R7
                end
                else if (step == 2'h0)
                    s = mk(1'b0, 1'b0, 1'b1,
                           sit == hols_pkg::SIT_LIMIT);     // R6 R8
                else if (step == 2'h1)
                    s = mk(1'b0, 1'b1, 1'b0, 1'b1);         // R6 R8
                else
                    s = mk(1'b1, 1'b0, 1'b0, 1'b0);         // R6 R8
            end
            hols_pkg::METHOD_PL_C:
            begin
                if (sit == hols_pkg::SIT_ACTIVE)
                begin
                    if (step == 2'h0)
                        s = mk(1'b0, 1'b1, 1'b0, 1'b0);     // R10
                    else
                        s = mk(1'b1, 1'b0, 1'b0, 1'b1);     // R10
                end
                else if (step == 2'h0)
                    s = mk(1'b0, 1'b0, 1'b1,
                           sit == hols_pkg::SIT_LIMIT);     // R9 R11
                else if (step == 2'h1)
                    s = mk(1'b0, 1'b1, 1'b0, 1'b0);         // R9 R11
                else
                    s = mk(1'b1, 1'b0, 1'b0, 1'b1);         // R9 R11
            end
            hols_pkg::METHOD_PL_D:
            begin
                if (sit == hols_pkg::SIT_ACTIVE)
                    s = mk(1'b1, 1'b1, 1'b0, 1'b0);         // R13
                else if (step == 2'h0)
                    s = mk(1'b0, 1'b0, 1'b1,
                           sit == hols_pkg::SIT_LIMIT);     // R12 R14
                else
                    s = mk(1'b1, 1'b1, 1'b0, 1'b0);         // R12 R14
            end
            default:
                s = mk(1'b1, 1'b0, 1'b0, 1'b0);  // Unsupported, never run
        endcase
        return s;
    endfunction : seg_of

    // Synchronised switch levels and edges
    logic [hols_pkg::IN_NUM-1:0] sw_level;
    logic [hols_pkg::IN_NUM-1:0] sw_rise;
    logic [hols_pkg::IN_NUM-1:0] sw_fall;

    // Start detection
    logic start_pulse;  // Control word went ready to go
    logic homing_on;    // Homing bit still held by master

    // Pins pass two flops before any use
    hols_sync_edge #(
        .WIDTH    (hols_pkg::IN_NUM)
    ) u_sync (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .async_in ({pos_limit_in, origin_in}),
        .level    (sw_level),
        .rise     (sw_rise),
        .fall     (sw_fall)
    );  // R16

    // Start transition watcher
    hols_start_det u_start (
        .ref_clk     (ref_clk),
        .reset       (reset),
        .ctrl_word   (ctrl_word),
        .start_pulse (start_pulse),
        .homing_on   (homing_on)
    );  // R15

    // Sequencer state
    hols_pkg::hols_state_t              state_reg;   // Current state
    hols_pkg::hols_state_t              state_next;
    logic [hols_pkg::METHOD_W-1:0]      method_reg;  // Method taken at start
    logic [hols_pkg::METHOD_W-1:0]      method_next;
    logic [1:0]                         sit_reg;     // Situation in use
    logic [1:0]                         sit_next;
    logic [1:0]                         step_reg;    // Segment index
    logic [1:0]                         step_next;
    logic [hols_pkg::POS_W-1:0]         home_reg;    // Latched home
    logic [hols_pkg::POS_W-1:0]         home_next;
    logic                               run_reg;     // Motion enable
    logic                               fast_reg;    // Speed select
    logic                               neg_reg;     // Direction select
    logic                               latch_reg;   // Home latched pulse

    // Decoded conditions
    wire logic running   = (state_reg == hols_pkg::ST_RUN);
    wire logic org_lvl   = sw_level[hols_pkg::IN_ORG];
    wire logic org_rise  = sw_rise[hols_pkg::IN_ORG];
    wire logic org_fall  = sw_fall[hols_pkg::IN_ORG];
    wire logic lim_rise  = sw_rise[hols_pkg::IN_LIM];
    wire logic method_ok = (homing_method >= hols_pkg::METHOD_ORG_ONLY) &&
                           (homing_method <= hols_pkg::METHOD_PL_D);
    wire logic uses_lim  = (method_reg != hols_pkg::METHOD_ORG_ONLY);

    // Current segment and its ending edge
    hols_pkg::hols_seg_t cur_seg;
    assign cur_seg = seg_of(method_reg, sit_reg, step_reg);

    wire logic end_hit   = cur_seg.on_fall ? org_fall : org_rise;
    // Limit only counts on the first fast run, before origin rise
    wire logic lim_turn  = running && uses_lim && !end_hit &&
                           (sit_reg == hols_pkg::SIT_CLEAR) &&
                           (step_reg == hols_pkg::STEP_FIRST) &&
                           lim_rise;                                // R17
    wire logic home_hit  = running && end_hit && cur_seg.last;      // R16
    wire logic step_hit  = running && end_hit && !cur_seg.last;
    wire logic abort     = running && !homing_on;
    wire logic new_start = !running && start_pulse;                 // R15

    // Next-state decode
    always_comb
    begin
        state_next  = state_reg;
        method_next = method_reg;
        sit_next    = sit_reg;
        step_next   = step_reg;
        home_next   = home_reg;
        if (new_start)
        begin
            // Situation picked from origin level at start
            method_next = homing_method;
            sit_next    = org_lvl ? hols_pkg::SIT_ACTIVE
                                  : hols_pkg::SIT_CLEAR;
            step_next   = hols_pkg::STEP_FIRST;
            state_next  = method_ok ? hols_pkg::ST_RUN
                                    : hols_pkg::ST_FAULT;
        end
        else if (abort)
        begin
            // Master withdrew homing: stop, keep old home
            state_next = hols_pkg::ST_IDLE;
        end
        else if (home_hit)
        begin
            // Position in the edge cycle becomes home
            home_next  = axis_pos;                                  // R16
            state_next = hols_pkg::ST_DONE;
        end
        else if (lim_turn)
        begin
            // Switch to limit path, restart its segments
            sit_next  = hols_pkg::SIT_LIMIT;                        // R17
            step_next = hols_pkg::STEP_FIRST;
        end
        else if (step_hit)
        begin
            // Reverse or slow down for the next segment
            step_next = step_reg + 2'h1;
        end
    end

    // Motion command for the coming segment
    hols_pkg::hols_seg_t nxt_seg;
    assign nxt_seg = seg_of(method_next, sit_next, step_next);
    wire logic run_next = (state_next == hols_pkg::ST_RUN);

    // State and index registers
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            state_reg  <= hols_pkg::ST_IDLE;
            method_reg <= 8'h00;
            sit_reg    <= hols_pkg::SIT_CLEAR;
            step_reg   <= hols_pkg::STEP_FIRST;
            home_reg   <= hols_pkg::HOME_POS_RST;
        end
        else
        begin
            state_reg  <= state_next;
            method_reg <= method_next;
            sit_reg    <= sit_next;
            step_reg   <= step_next;
            home_reg   <= home_next;
        end
    end

    // Registered motion outputs; zeroed whenever not running
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            run_reg   <= 1'b0;
            fast_reg  <= 1'b0;
            neg_reg   <= 1'b0;
            latch_reg <= 1'b0;
        end
        else
        begin
            run_reg   <= run_next;
            fast_reg  <= run_next & nxt_seg.fast;
            neg_reg   <= run_next & nxt_seg.neg;
            latch_reg <= home_hit && !abort;                        // R16
        end
    end

    // Output drive
    assign move_en      = run_reg;
    assign speed_fast   = fast_reg;
    assign dir_neg      = neg_reg;
    assign home_pos     = home_reg;
    assign home_latch   = latch_reg;
    assign homing_busy  = running;
    assign homing_done  = (state_reg == hols_pkg::ST_DONE);         // R16
    assign homing_fault = (state_reg == hols_pkg::ST_FAULT);

endmodule : hols_seq

`default_nettype wire

// ===== design/hols_none.sv
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// ===== testbench/hols_seq_asserts.sv
`timescale 1ns/100ps
`default_nettype none

module hols_seq_asserts (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        reset,
    // Switches, master and feedback
    input  wire logic        origin_in,
    input  wire logic        pos_limit_in,
    input  wire logic [15:0] ctrl_word,
    input  wire logic [7:0]  homing_method,
    input  wire logic [31:0] axis_pos,
    // Motion and result outputs
    input  wire logic        move_en,
    input  wire logic        speed_fast,
    input  wire logic        dir_neg,
    input  wire logic [31:0] home_pos,
    input  wire logic        home_latch,
    input  wire logic        homing_busy,
    input  wire logic        homing_done,
    input  wire logic        homing_fault
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    // Method code within the supported range
    wire m_ok = homing_method >= 8'h16 && homing_method <= 8'h1A;

    // Start: control word steps from enabled to homing go
    property p_start;
        (ctrl_word == 16'h001F && $past(ctrl_word) == 16'h000F && m_ok
            && !homing_busy) |-> ##[1:2] homing_busy;
    endproperty
    a_start: assert property (p_start)
        else $error("start not taken");

    // Bad method refused with a fault and no motion
    property p_fault;
        (ctrl_word == 16'h001F && $past(ctrl_word) == 16'h000F && !m_ok
            && !homing_busy) |-> ##[1:2] (homing_fault && !move_en);
    endproperty
    a_fault: assert property (p_fault)
        else $error("bad method not refused");

    // Home latch lasts one cycle
    property p_latch_pulse;
        home_latch |=> !home_latch;
    endproperty
    a_latch_pulse: assert property (p_latch_pulse)
        else $error("latch pulse too long");

    // Latch: position captured, motion stopped, done raised
    property p_latch;
        home_latch |-> homing_done && !move_en && $past(homing_busy)
            && (home_pos == $past(axis_pos) || home_pos == $past(axis_pos, 2));
    endproperty
    a_latch: assert property (p_latch)
        else $error("home latch wrong");

    // Running means moving
    property p_busy_moves;
        homing_busy |-> move_en;
    endproperty
    a_busy_moves: assert property (p_busy_moves)
        else $error("busy without motion");

    // Speed and direction quiet while stopped
    property p_quiet;
        !move_en |-> !speed_fast && !dir_neg;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("command while stopped");

    // Method 22 only ever runs slow
    property p_slow22;
        homing_busy && homing_method == 8'h16 |-> !speed_fast;
    endproperty
    a_slow22: assert property (p_slow22)
        else $error("fast run in origin only method");

    // Dropping the homing bit stops the run
    property p_abort;
        homing_busy && !ctrl_word[4] |=> !homing_busy && !move_en;
    endproperty
    a_abort: assert property (p_abort)
        else $error("abort ignored");

    // Main scenarios reached
    c_home:  cover property (home_latch);
    c_fault: cover property (homing_fault);
    c_abort: cover property (homing_busy && !ctrl_word[4]);
endmodule : hols_seq_asserts

`default_nettype wire

// ===== testbench/hols_axis_model.sv
`timescale 1ns/100ps
`default_nettype none

module hols_axis_model (
    // Clock
    input  wire logic        ref_clk,
    // Motion commands
    input  wire logic        move_en,
    input  wire logic        speed_fast,
    input  wire logic        dir_neg,
    // Position preset from the bench
    input  wire logic        load,
    input  wire logic [31:0] load_pos,
    // Switch levels and position
    output logic             origin_in,
    output logic             pos_limit_in,
    output logic      [31:0] axis_pos
);
    // Origin cam window and limit threshold
    localparam int ORG_LO = 100;
    localparam int ORG_HI = 199;
    localparam int LIM_AT = 400;

    logic [7:0] seg_log;   // Segments seen, {fast, neg} each
    int         seg_cnt;   // Segments logged so far
    logic [1:0] seg_last;  // Last command seen

    // Switches follow position with no bounce
    assign origin_in    = int'(axis_pos) >= ORG_LO
                          && int'(axis_pos) <= ORG_HI;
    assign pos_limit_in = int'(axis_pos) >= LIM_AT;

    // Move four steps fast, one slow; log up to four new segments
    always @(posedge ref_clk)
    begin
        if (load)
        begin
            axis_pos <= load_pos;
            seg_log  <= 8'h00;
            seg_cnt  <= 0;
        end
        else if (move_en)
        begin
            axis_pos <= dir_neg ? axis_pos - (speed_fast ? 4 : 1)
                                : axis_pos + (speed_fast ? 4 : 1);
            if ((seg_cnt == 0 || seg_last != {speed_fast, dir_neg})
                && seg_cnt < 4)
            begin
                seg_log[2*seg_cnt +: 2] <= {speed_fast, dir_neg};
                seg_cnt <= seg_cnt + 1;
            end
            seg_last <= {speed_fast, dir_neg};
        end
    end
endmodule : hols_axis_model

`default_nettype wire

// ===== testbench/hols_seq_tb.sv
`timescale 1ns/100ps
`default_nettype none

module hols_seq_tb;
    // One row: method, start, segments {fast,neg}, home edge
    typedef struct {
        logic [7:0]  method;
        logic [31:0] start;
        logic [7:0]  segs;
        int          home;
        bit          neg;
    } hols_row_t;

    logic        ref_clk       = 1'b0;
    logic        reset         = 1'b1;
    logic [15:0] ctrl_word     = 16'h0000;
    logic [7:0]  homing_method = 8'h16;
    logic        load          = 1'b1;
    logic [31:0] load_pos      = 32'h0000_0000;
    logic        origin_in;
    logic        pos_limit_in;
    logic [31:0] axis_pos;
    logic        move_en;
    logic        speed_fast;
    logic        dir_neg;
    logic [31:0] home_pos;
    logic        home_latch;
    logic        homing_busy;
    logic        homing_done;
    logic        homing_fault;
    int          err_total   = 0;
    int          check_count = 0;
    int          cyc         = 0;
    logic [31:0] kept;

    // Off rows start at 0 or 300, on rows inside the cam
    hols_row_t rows [14] = '{
        '{8'h16, 300, 8'h01, 199, 1}, '{8'h16, 150, 8'h04, 199, 1},
        '{8'h17,   0, 8'h06,  99, 1}, '{8'h17, 150, 8'h01,  99, 1},
        '{8'h17, 300, 8'h1E,  99, 1}, '{8'h18,   0, 8'h06, 100, 0},
        '{8'h18, 150, 8'h01, 100, 0}, '{8'h18, 300, 8'h1E, 100, 0},
        '{8'h19,   0, 8'h12, 199, 1}, '{8'h19, 150, 8'h04, 199, 1},
        '{8'h19, 300, 8'h4E, 199, 1}, '{8'h1A,   0, 8'h02, 200, 0},
        '{8'h1A, 150, 8'h00, 200, 0}, '{8'h1A, 300, 8'h0E, 200, 0}};

    always #12.5 ref_clk = ~ref_clk;

    hols_seq hols_seq_inst (
        .ref_clk(ref_clk), .reset(reset), .origin_in(origin_in),
        .pos_limit_in(pos_limit_in), .ctrl_word(ctrl_word),
        .homing_method(homing_method), .axis_pos(axis_pos),
        .move_en(move_en), .speed_fast(speed_fast), .dir_neg(dir_neg),
        .home_pos(home_pos), .home_latch(home_latch),
        .homing_busy(homing_busy), .homing_done(homing_done),
        .homing_fault(homing_fault));

    hols_axis_model hols_axis_model_inst (
        .ref_clk(ref_clk), .move_en(move_en), .speed_fast(speed_fast),
        .dir_neg(dir_neg), .load(load), .load_pos(load_pos),
        .origin_in(origin_in), .pos_limit_in(pos_limit_in),
        .axis_pos(axis_pos));

    // Advance n edges, then step just past the edge
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #2;
    endtask : tick

    // Compare one value, count and report
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // Motion, status flags and home position cleared after reset
    task automatic chk_idle();
        chk({move_en, homing_busy, homing_done, homing_fault}, 0);
        chk(home_pos, 0);
    endtask : chk_idle

    // Preset axis, let the synchronisers settle, then start
    task automatic start(input logic [7:0] m, input logic [31:0] p);
        homing_method = m;
        load_pos      = p;
        load          = 1'b1;
        tick(1);
        load          = 1'b0;
        ctrl_word     = hols_pkg::CW_OP_ENABLED;
        tick(5);
        ctrl_word     = hols_pkg::CW_HOMING_GO;
        tick(3);
    endtask : start

    // Full homing run checked against the segment table
    task automatic run_row(input hols_row_t r);
        int n;
        start(r.method, r.start);
        chk(homing_busy, 1);
        n = 0;
        while (home_latch !== 1'b1 && n < 3000)
        begin
            tick(1);
            n++;
        end
        chk(home_latch, 1);
        chk(hols_axis_model_inst.seg_log, r.segs);
        chk(hols_axis_model_inst.seg_log, r.segs);
        chk(r.neg ? r.home - int'(home_pos) <= 4 && int'(home_pos) <= r.home
                  : int'(home_pos) - r.home <= 4 && int'(home_pos) >= r.home,
            1);
        chk({homing_done, move_en}, 2'b10);
        tick(1);
        chk(home_latch, 0);
        ctrl_word = hols_pkg::CW_OP_ENABLED;
        tick(1);
    endtask : run_row

    // Report counts and give the verdict
    task automatic tally_and_finish();
        $display("errors %0d checks %0d", err_total, check_count);
        if (err_total == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish

    // Cut a hang short
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            err_total++;
            tally_and_finish();
        end
    end

    initial
    begin
        tick(4);
        reset = 1'b0;
        tick(1);
        chk_idle();
        foreach (rows[i])
            run_row(rows[i]);
        // Code just below the supported range is refused
        start(8'h15, 0);
        chk({homing_fault, move_en}, 2'b10);
        // Abort mid-run keeps the last home
        kept = home_pos;
        start(8'h1A, 0);
        chk({homing_fault, homing_busy}, 2'b01);
        ctrl_word = hols_pkg::CW_OP_ENABLED;
        tick(2);
        chk({homing_busy, move_en, homing_done}, 0);
        chk(home_pos, kept);
        // Refused from idle, so the fault cannot be a leftover
        start(8'h1B, 0);
        chk({homing_fault, move_en}, 2'b10);
        // Reset in mid-run clears all
        start(8'h18, 0);
        reset = 1'b1;
        tick(2);
        chk_idle();
        reset = 1'b0;
        tick(1);
        chk_idle();
        tally_and_finish();
    end
endmodule : hols_seq_tb

bind hols_seq hols_seq_asserts hols_seq_asserts_inst (
    .ref_clk(ref_clk), .reset(reset), .origin_in(origin_in),
    .pos_limit_in(pos_limit_in), .ctrl_word(ctrl_word),
    .homing_method(homing_method), .axis_pos(axis_pos),
    .move_en(move_en), .speed_fast(speed_fast), .dir_neg(dir_neg),
    .home_pos(home_pos), .home_latch(home_latch),
    .homing_busy(homing_busy), .homing_done(homing_done),
    .homing_fault(homing_fault));

`default_nettype wire
